// file: include/cccd_pkg.sv
// Package for the calibration command decoder: codes, lengths, limits, carriers
package cccd_pkg;
	localparam logic [15:0] RX_GROUP_RST = 16'hFFA5;
	localparam logic [7:0] CMD_OFS_LOAD = 8'hAC;
	localparam logic [7:0] CMD_OFS_SAVE = 8'hCA;
	localparam logic [7:0] CMD_CAP_LOAD = 8'hAD;
	localparam logic [7:0] CMD_CAP_SAVE = 8'hDA;
	localparam logic [7:0] CMD_SEN_LOAD = 8'hAE;
	localparam logic [7:0] CMD_SEN_SAVE = 8'hEA;
	localparam logic [3:0] LEN_OFS = 4'h6;
	localparam logic [3:0] LEN_CAP = 4'h5;
	localparam logic [3:0] LEN_SEN = 4'h4;
	localparam logic [7:0] SIGN_POS = 8'h00;
	localparam logic [7:0] SIGN_NEG = 8'h01;
	localparam logic [23:0] OFS_MAX_KG = 24'h00EA60;
	localparam logic [23:0] OFS_MAX_LB = 24'h0204B6;
	localparam logic [23:0] CAP_MAX_KG = 24'h00C350;
	localparam logic [23:0] CAP_MAX_LB = 24'h01AE97;
	localparam logic [15:0] SEN_MAX = 16'h1388;
	localparam logic [24:0] OFS_RST = 25'h0000000;
	localparam logic [23:0] CAP_RST = 24'h000000;
	localparam logic [15:0] SEN_RST = 16'h0000;
	localparam int N_INPUTS = 4;

	// One received frame, data bytes in arrival order
	typedef struct packed {
		logic [15:0] group;
		logic [3:0] len;
		logic [7:0][7:0] data;
	} cccd_frame_t;

	// One write to the setpoints of every selected input
	typedef struct packed {
		logic ofs_we;
		logic cap_we;
		logic sen_we;
		logic [24:0] ofs;
		logic [23:0] cap;
		logic [15:0] sen;
	} cccd_wr_t;
endpackage : cccd_pkg

// file: src/cccd_setpoint.sv
// One input's setpoint store
`timescale 1ns/10ps
`default_nettype none
module cccd_setpoint (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Write from decoder
	input wire logic sel_i,
	input wire cccd_pkg::cccd_wr_t wr_i,
	// Stored values
	output logic [24:0] ofs_o,
	output logic [23:0] cap_o,
	output logic [15:0] sen_o
);
	logic [24:0] ofs_q, ofs_d;
	logic [23:0] cap_q, cap_d;
	logic [15:0] sen_q, sen_d;

	always_comb begin
		ofs_d = ofs_q;
		cap_d = cap_q;
		sen_d = sen_q;
		if (sel_i && wr_i.ofs_we) begin
			ofs_d = wr_i.ofs;
		end
		if (sel_i && wr_i.cap_we) begin
			cap_d = wr_i.cap;
		end
		if (sel_i && wr_i.sen_we) begin
			sen_d = wr_i.sen;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			ofs_q <= cccd_pkg::OFS_RST;
			cap_q <= cccd_pkg::CAP_RST;
			sen_q <= cccd_pkg::SEN_RST;
		end else begin
			ofs_q <= ofs_d;
			cap_q <= cap_d;
			sen_q <= sen_d;
		end
	end

	assign ofs_o = ofs_q;
	assign cap_o = cap_q;
	assign sen_o = sen_q;
endmodule : cccd_setpoint
`default_nettype wire

// file: src/cccd_decoder.sv
// Calibration command decoder for offset, capacity and sensitivity frames
//
// Function
// RULE1 - Accept only on configurable receive group, default FFA5
// RULE2 - Option bits 0-3 select inputs 1-4
// RULE3 - Sign 00 positive, 01 negative
// RULE4 - Offset frame: cmd, option, sign, three data
// RULE5 - Offset codes: AC load, CA save
// RULE6 - Offset magnitude signed by sign byte
// RULE7 - Sender keeps offset within unit limit
// RULE8 - Offset and capacity use per-input weight unit
// RULE9 - Three data bytes most significant first
// RULE10 - Offset save ignores bytes after command
// RULE11 - Save writes setpoints to flash; the code only pulses save_o and leaves the calibration state
// RULE12 - Capacity frame: cmd, option, three unsigned bytes
// RULE13 - Capacity codes: AD load, DA save
// RULE14 - Capacity non-negative, within unit limit
// RULE15 - Capacity save ignores following four bytes
// RULE16 - Sensitivity frame: cmd, option, two data
// RULE17 - Sensitivity codes: AE load, EA save
// RULE18 - Sensitivity 0 to 5000, hundredths mV/V
// RULE19 - Sensitivity bytes most significant first
// RULE20 - Sensitivity save ignores following three bytes
// RULE21 - Discard bad code, length or range
// RULE22 - Ignore option bits above bit 3
`timescale 1ns/10ps
`default_nettype none
module cccd_decoder #(
	parameter logic [15:0] RX_GROUP = cccd_pkg::RX_GROUP_RST
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// Configuration
	input wire logic [15:0] rx_group_i,
	input wire logic rx_group_use_i,
	input wire logic [3:0] unit_lb_i,
	// Frame from CAN receiver
	input wire logic frame_valid_i,
	input wire cccd_pkg::cccd_frame_t frame_i,
	// Setpoints, per input
	output logic [4*25-1:0] ofs_o,
	output logic [4*24-1:0] cap_o,
	output logic [4*16-1:0] sen_o,
	// Status
	output logic save_o,
	output logic accept_o,
	output logic reject_o,
	output logic cal_active_o
);
	typedef enum logic [1:0] {CCCD_IDLE, CCCD_CAL} cccd_state_t;

	cccd_state_t state_q, state_d;
	logic save_q, save_d;
	logic accept_q, accept_d;
	logic reject_q, reject_d;
	cccd_pkg::cccd_wr_t wr;
	logic [3:0] sel;
	logic [15:0] group;
	logic [7:0] cmd;
	logic [23:0] mag24;
	logic [23:0] mag_cap;
	logic [15:0] mag16;
	logic ok;
	logic unit_ok;

	assign group = rx_group_use_i ? rx_group_i : RX_GROUP; // RULE1
	assign cmd = frame_i.data[0];
	assign mag24 = {frame_i.data[3], frame_i.data[4], frame_i.data[5]}; // RULE9
	assign mag_cap = {frame_i.data[2], frame_i.data[3], frame_i.data[4]}; // RULE9
	assign mag16 = {frame_i.data[2], frame_i.data[3]}; // RULE19

	always_comb begin
		wr = '0;
		sel = 4'h0;
		ok = 1'b0;
		unit_ok = 1'b1;
		state_d = state_q;
		save_d = 1'b0;
		accept_d = 1'b0;
		reject_d = 1'b0;
		if (frame_valid_i && frame_i.group == group) begin
			unique case (cmd)
				cccd_pkg::CMD_OFS_LOAD: begin
					// A multi-input write must fit every selected unit
					for (int i = 0; i < cccd_pkg::N_INPUTS; i++) begin
						if (frame_i.data[1][i] && mag24 > (unit_lb_i[i] ? cccd_pkg::OFS_MAX_LB : cccd_pkg::OFS_MAX_KG)) begin
							unit_ok = 1'b0; // RULE7 RULE8
						end
					end
					ok = frame_i.len == cccd_pkg::LEN_OFS && unit_ok
						&& (frame_i.data[2] == cccd_pkg::SIGN_POS || frame_i.data[2] == cccd_pkg::SIGN_NEG); // RULE4 RULE3
					wr.ofs_we = ok; // RULE5
					wr.ofs = (frame_i.data[2] == cccd_pkg::SIGN_NEG) ? 25'(-{1'b0, mag24}) : {1'b0, mag24}; // RULE6
				end
				cccd_pkg::CMD_CAP_LOAD: begin
					for (int i = 0; i < cccd_pkg::N_INPUTS; i++) begin
						if (frame_i.data[1][i] && mag_cap > (unit_lb_i[i] ? cccd_pkg::CAP_MAX_LB : cccd_pkg::CAP_MAX_KG)) begin
							unit_ok = 1'b0; // RULE14 RULE8
						end
					end
					ok = frame_i.len == cccd_pkg::LEN_CAP && unit_ok; // RULE12
					wr.cap_we = ok; // RULE13
					wr.cap = mag_cap;
				end
				cccd_pkg::CMD_SEN_LOAD: begin
					ok = frame_i.len == cccd_pkg::LEN_SEN && mag16 <= cccd_pkg::SEN_MAX; // RULE16 RULE18
					wr.sen_we = ok; // RULE17
					wr.sen = mag16;
				end
				// Save codes look at the command byte and the frame length only
				cccd_pkg::CMD_OFS_SAVE: begin
					ok = frame_i.len == cccd_pkg::LEN_OFS; // RULE10 RULE5
					save_d = ok; // RULE11
				end
				cccd_pkg::CMD_CAP_SAVE: begin
					ok = frame_i.len == cccd_pkg::LEN_CAP; // RULE15 RULE13
					save_d = ok; // RULE11
				end
				cccd_pkg::CMD_SEN_SAVE: begin
					ok = frame_i.len == cccd_pkg::LEN_SEN; // RULE20 RULE17
					save_d = ok; // RULE11
				end
				default: begin
					ok = 1'b0; // RULE21
				end
			endcase
			sel = ok ? frame_i.data[1][3:0] : 4'h0; // RULE2 RULE22 RULE21
			accept_d = ok;
			reject_d = !ok; // RULE21
			if (ok) begin
				state_d = save_d ? CCCD_IDLE : CCCD_CAL;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			state_q <= CCCD_IDLE;
			save_q <= 1'b0;
			accept_q <= 1'b0;
			reject_q <= 1'b0;
		end else begin
			state_q <= state_d;
			save_q <= save_d;
			accept_q <= accept_d;
			reject_q <= reject_d;
		end
	end

	for (genvar g = 0; g < cccd_pkg::N_INPUTS; g++) begin : g_sp
		cccd_setpoint u_sp (
			.clk_i(clk_i),
			.sys_rst_i(sys_rst_i),
			.sel_i(sel[g]),
			.wr_i(wr),
			.ofs_o(ofs_o[g*25 +: 25]),
			.cap_o(cap_o[g*24 +: 24]),
			.sen_o(sen_o[g*16 +: 16])
		);
	end

	assign save_o = save_q;
	assign accept_o = accept_q;
	assign reject_o = reject_q;
	assign cal_active_o = (state_q == CCCD_CAL);
endmodule : cccd_decoder
`default_nettype wire

// file: bench/cccd_decoder_properties.sv
// Checker for the calibration command decoder
`timescale 1ns/10ps
`default_nettype none
module cccd_decoder_chk #(
	parameter logic [15:0] RX_GROUP = cccd_pkg::RX_GROUP_RST
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] rx_group_i,
	input wire logic rx_group_use_i,
	input wire logic frame_valid_i,
	input wire cccd_pkg::cccd_frame_t frame_i,
	input wire logic [99:0] ofs_o,
	input wire logic [95:0] cap_o,
	input wire logic [63:0] sen_o,
	input wire logic save_o,
	input wire logic accept_o,
	input wire logic reject_o,
	input wire logic cal_active_o
);
	cccd_pkg::cccd_frame_t p_q;
	logic [7:0] c;
	logic ours;
	logic [24:0] m;
	always_ff @(posedge clk_i) p_q <= frame_i;
	assign c = frame_i.data[0];
	assign m = {1'b0, p_q.data[3], p_q.data[4], p_q.data[5]};
	// Same group choice as the decoder, including a parameter override
	assign ours = frame_valid_i && frame_i.group == (rx_group_use_i ? rx_group_i : RX_GROUP);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	AST_GROUP: assert property (frame_valid_i && !ours |=> !accept_o && !reject_o) else $error("foreign frame");
	AST_CODE: assert property (ours && !(c inside {8'hAC, 8'hCA, 8'hAD, 8'hDA, 8'hAE, 8'hEA}) |=> reject_o)
		else $error("unknown code kept");
	AST_LEN: assert property (ours && c == 8'hAC && frame_i.len != 4'h6 |=> reject_o) else $error("bad length");
	AST_SEN_RANGE: assert property (ours && c == 8'hAE && frame_i.len == 4'h4
		&& {frame_i.data[2], frame_i.data[3]} > 16'h1388 |=> reject_o) else $error("sensitivity range kept");
	AST_OFS: assert property (accept_o && p_q.data[0] == 8'hAC && p_q.data[1][0] |->
		ofs_o[24:0] == (p_q.data[2][0] ? 25'h0 - m : m)) else $error("offset wrong");
	AST_CAP: assert property (accept_o && p_q.data[0] == 8'hAD && p_q.data[1][2] |->
		cap_o[71:48] == {p_q.data[2], p_q.data[3], p_q.data[4]}) else $error("capacity wrong");
	AST_SEN: assert property (accept_o && p_q.data[0] == 8'hAE && p_q.data[1][1] |->
		sen_o[31:16] == {p_q.data[2], p_q.data[3]}) else $error("sensitivity wrong");
	AST_SAVE: assert property (ours && c == 8'hCA && frame_i.len == 4'h6 |=> save_o && !cal_active_o)
		else $error("save missed");
	AST_KEEP: assert property (reject_o |-> ofs_o == $past(ofs_o) && cap_o == $past(cap_o)
		&& sen_o == $past(sen_o)) else $error("reject changed setpoint");
	cover property (save_o);
	cover property (reject_o);
	cover property (accept_o && cal_active_o);
endmodule : cccd_decoder_chk
bind cccd_decoder cccd_decoder_chk #(.RX_GROUP(RX_GROUP)) u_chk (.clk_i, .sys_rst_i, .rx_group_i, .rx_group_use_i,
	.frame_valid_i,
	.frame_i, .ofs_o, .cap_o, .sen_o, .save_o, .accept_o, .reject_o, .cal_active_o);
`default_nettype wire

// file: bench/cccd_sender.sv
// Frame source standing in for the remote calibration tool
`timescale 1ns/10ps
`default_nettype none
module cccd_sender (
	// Clock
	input wire logic clk_i,
	// Frame to decoder
	output logic frame_valid_o,
	output cccd_pkg::cccd_frame_t frame_o
);
	initial begin
		frame_valid_o = 1'b0;
		frame_o = '0;
	end
	// First byte sent lands in data[0]; unit limits are the caller's to keep
	task automatic send(input logic [15:0] g, input logic [3:0] n, input logic [63:0] d);
		@(negedge clk_i);
		frame_valid_o = 1'b1;
		frame_o.group = g;
		frame_o.len = n;
		for (int i = 0; i < 8; i++) frame_o.data[i] = d[63 - 8 * i -: 8];
	endtask : send
	// Released frame shows junk, not the last value
	task automatic idle();
		@(negedge clk_i);
		frame_valid_o = 1'b0;
		frame_o = ~frame_o;
	endtask : idle
endmodule : cccd_sender
`default_nettype wire

// file: bench/test_cccd_decoder.sv
// Testbench for the calibration command decoder
`timescale 1ns/10ps
`default_nettype none
module test_cccd_decoder;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [15:0] grp = 16'hFFA5;
	logic [15:0] rx_group_i = 16'h1234;
	logic rx_group_use_i = 1'b0;
	logic [3:0] unit_lb_i = 4'h0;
	logic frame_valid_i;
	cccd_pkg::cccd_frame_t frame_i;
	logic [99:0] ofs_o;
	logic [95:0] cap_o;
	logic [63:0] sen_o;
	logic save_o, accept_o, reject_o, cal_active_o;
	int failures = 0;
	int num_checks = 0;
	int cyc = 0;
	always #50 clk_i = ~clk_i;
	cccd_sender snd (.clk_i, .frame_valid_o(frame_valid_i), .frame_o(frame_i));
	cccd_decoder DUT (.clk_i, .sys_rst_i, .rx_group_i, .rx_group_use_i, .unit_lb_i, .frame_valid_i,
		.frame_i, .ofs_o, .cap_o, .sen_o, .save_o, .accept_o, .reject_o, .cal_active_o);
	task automatic check(input logic [24:0] seen, input logic [24:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check
	// Pulses are looked at in the one cycle they stand
	task automatic xfer(input logic [3:0] n, input logic [63:0] d, input logic [2:0] want);
		snd.send(grp, n, d);
		snd.idle();
		check(25'({accept_o, reject_o, save_o}), 25'(want));
	endtask : xfer
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : complete_run
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 2000) begin
			failures++;
			complete_run();
		end
	end
	initial begin
		repeat (20) @(negedge clk_i);
		sys_rst_i = 1'b0;
		xfer(4'h6, 64'hAC0A000075300000, 3'h4);
		check(ofs_o[49:25], 25'h0007530);
		check(25'(cal_active_o), 25'h1);
		xfer(4'h6, 64'hCAFFFFFFFFFF0000, 3'h5);
		check(25'(cal_active_o), 25'h0);
		xfer(4'h6, 64'hACF10100EA600000, 3'h4);
		check(ofs_o[24:0], 25'h1FF15A0);
		check(ofs_o[49:25], 25'h0007530);
		xfer(4'h6, 64'hAC010000EA610000, 3'h2);
		xfer(4'h6, 64'hAC01020000010000, 3'h2);
		unit_lb_i = 4'h1;
		xfer(4'h6, 64'hAC010000EA610000, 3'h4);
		check(ofs_o[24:0], 25'h000EA61);
		xfer(4'h6, 64'hAC030000EA610000, 3'h2);
		check(ofs_o[24:0], 25'h000EA61);
		check(ofs_o[49:25], 25'h0007530);
		xfer(4'h5, 64'hAD05002710000000, 3'h4);
		check(25'(cap_o[71:48]), 25'h0002710);
		xfer(4'h5, 64'hAD0101AE98000000, 3'h2);
		xfer(4'h5, 64'hDA01010101000000, 3'h5);
		snd.send(grp, 4'h4, 64'hAE020A0F00000000);
		snd.send(grp, 4'h4, 64'hAE02138900000000);
		snd.idle();
		check(25'({accept_o, reject_o}), 25'h1);
		check(25'(sen_o[31:16]), 25'h0000A0F);
		xfer(4'h4, 64'hEA0F0F0F00000000, 3'h5);
		xfer(4'h5, 64'hAC01000000010000, 3'h2);
		xfer(4'h2, 64'h5501000000000000, 3'h2);
		rx_group_use_i = 1'b1;
		xfer(4'h4, 64'hAE01000100000000, 3'h0);
		grp = 16'h1234;
		xfer(4'h4, 64'hAE01000100000000, 3'h4);
		check(25'(sen_o[15:0]), 25'h0000001);
		complete_run();
	end
endmodule : test_cccd_decoder
`default_nettype wire
